// file: src/sram_port_regs.svh
// Reset values and fixed counts for the quad-rate SRAM port logic.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

`define BURST_LEN 3'h4
`define BEAT_W 2
`define SYNC_RST 1'b0
`define SEL_IDLE 2'h3
`define RDATA_RST 36'h0_0000_0000
`define RD_LEFT_RST 3'h0
`define DOC_DATA_W 36
`define DOC_ADDR_W 19
`define DOC_MASK_W 4
`define WFIFO_DEPTH 8

`endif

// file: src/sram_port_pkg.sv
// Types shared by the quad-rate SRAM port logic.
// Assumes sram_port_regs.svh is on the include path.
`include "sram_port_regs.svh"

package sram_port_pkg;

  // Write burst states, Gray coded along the beat sequence
  typedef enum logic [2:0] {
    W_IDLE = 3'b000,
    W_B0 = 3'b001,
    W_B1 = 3'b011,
    W_B2 = 3'b010,
    W_B3 = 3'b110
  } wr_state_e;

endpackage : sram_port_pkg

// file: src/quad_rate_sram_port_logic.sv
// Port logic of a burst-of-four SRAM with separate read and write data ports.
// Assumes all pins, including the timing clocks, are asynchronous to ref_clk
// and toggle slowly enough that ref_clk sees every edge.
`timescale 1ns/1ps
`include "sram_port_regs.svh"

// ----------------------------------------
// Write beat buffer
// ----------------------------------------
module sync_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `WFIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  wire full = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = store[rd_ptr[PW-1:0]];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) store[wr_ptr[PW-1:0]] <= in_data;
  end
endmodule : sync_word_fifo

// ----------------------------------------
// Device port logic
// ----------------------------------------
module quad_rate_sram_port_logic
  import sram_port_pkg::*;
#(
  parameter int DATA_W = `DOC_DATA_W,
  parameter int ADDR_W = `DOC_ADDR_W,
  parameter int MASK_W = `DOC_MASK_W,
  parameter int MEM_ADDR_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_clk_p,
  input wire logic in_clk_n,
  input wire logic out_clk_p,
  input wire logic out_clk_n,
  input wire logic single_clock_mode,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic [MASK_W-1:0] byte_write_mask_n,
  output logic [DATA_W-1:0] read_data,
  output logic read_data_oe,
  output logic return_strobe
);
  localparam int LANE_W = (DATA_W == 8) ? 4 : 9;
  localparam int DOC_ADDR = (DATA_W == 36) ? 19 : (DATA_W == 18) ? 20 : 21;
  localparam int IDX_W = MEM_ADDR_W + `BEAT_W;
  localparam int MEM_DEPTH = 1 << IDX_W;
  localparam int PIN_W = 7 + ADDR_W + DATA_W + MASK_W;
  localparam int FW = IDX_W + MASK_W + DATA_W;
  // Selects reset to their idle level so no false request follows reset
  localparam logic [PIN_W-1:0] PIN_IDLE = PIN_W'(`SEL_IDLE) << (PIN_W - 7);

  if (DATA_W != 8 && DATA_W != 9 && DATA_W != 18 && DATA_W != 36) begin : g_bad_data_w
    $error("DATA_W must be 8, 9, 18 or 36");
  end
  if (ADDR_W != DOC_ADDR) begin : g_bad_addr_w
    $error("ADDR_W does not match DATA_W");
  end
  if (MASK_W * LANE_W != DATA_W) begin : g_bad_mask_w
    $error("MASK_W does not match DATA_W");
  end
  if (MEM_ADDR_W < 1 || MEM_ADDR_W > ADDR_W) begin : g_bad_mem_addr_w
    $error("MEM_ADDR_W out of range");
  end

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [3:0] clk_prev;
  wire [PIN_W-1:0] pin_raw = {in_clk_p, in_clk_n, out_clk_p, out_clk_n, single_clock_mode,
    write_port_select_n, read_port_select_n, addr, write_data, byte_write_mask_n};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      clk_prev <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[PIN_W-1 -: 4];
    end
  end

  wire [MASK_W-1:0] mask_s = pin_sync[MASK_W-1:0];
  wire [DATA_W-1:0] wdata_s = pin_sync[MASK_W +: DATA_W];
  wire [ADDR_W-1:0] addr_s = pin_sync[MASK_W + DATA_W +: ADDR_W];
  wire rd_sel_n_s = pin_sync[PIN_W-7];
  wire wr_sel_n_s = pin_sync[PIN_W-6];
  wire single_s = pin_sync[PIN_W-5];
  wire [3:0] clk_s = pin_sync[PIN_W-1 -: 4];
  wire [3:0] clk_rise = clk_s & ~clk_prev;
  wire k_p_rise = clk_rise[3];
  wire k_n_rise = clk_rise[2];
  wire launch_p_rise = single_s ? clk_rise[3] : clk_rise[1];
  wire launch_n_rise = single_s ? clk_rise[2] : clk_rise[0];
  wire launch_edge = launch_p_rise | launch_n_rise;
  wire strobe_src = single_s ? clk_s[3] : clk_s[1];

  // ----------------------------------------
  // Write burst sequencer
  // ----------------------------------------
  wr_state_e wstate;
  wr_state_e next_wstate;
  logic [MEM_ADDR_W-1:0] wr_addr;
  logic [MEM_ADDR_W-1:0] next_wr_addr;
  logic [`BEAT_W-1:0] beat_num;
  logic beat_on_neg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out;

  wire write_start = k_p_rise && !wr_sel_n_s;
  always_comb begin
    beat_num = 2'h0;
    beat_on_neg = 1'b0;
    case (wstate)
      W_B0: begin beat_num = 2'h0; beat_on_neg = 1'b1; end
      W_B1: begin beat_num = 2'h1; beat_on_neg = 1'b0; end
      W_B2: begin beat_num = 2'h2; beat_on_neg = 1'b1; end
      W_B3: begin beat_num = 2'h3; beat_on_neg = 1'b0; end
      default: begin beat_num = 2'h0; beat_on_neg = 1'b0; end
    endcase
  end
  wire beat_edge = beat_on_neg ? k_n_rise : k_p_rise;
  wire beat_take = (wstate != W_IDLE) && beat_edge;
  wire beat_push = beat_take && fifo_in_ready;

  always_comb begin
    next_wstate = wstate;
    next_wr_addr = wr_addr;
    case (wstate)
      W_IDLE: if (write_start) begin
        next_wstate = W_B0;
        next_wr_addr = addr_s[MEM_ADDR_W-1:0];
      end
      W_B0: if (beat_edge) next_wstate = W_B1;
      W_B1: if (beat_edge) next_wstate = W_B2;
      W_B2: if (beat_edge) next_wstate = W_B3;
      W_B3: if (beat_edge) begin
        next_wstate = write_start ? W_B0 : W_IDLE;
        if (write_start) next_wr_addr = addr_s[MEM_ADDR_W-1:0];
      end
      default: next_wstate = W_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wstate <= W_IDLE;
      wr_addr <= '0;
    end else begin
      wstate <= next_wstate;
      wr_addr <= next_wr_addr;
    end
  end

  // ----------------------------------------
  // Beat buffer and array write
  // ----------------------------------------
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic read_take;
  wire [FW-1:0] fifo_in = {wr_addr, beat_num, mask_s, wdata_s};
  wire drain = fifo_out_valid && !read_take;
  wire [IDX_W-1:0] drain_idx = fifo_out[FW-1 -: IDX_W];
  wire [MASK_W-1:0] drain_mask_n = fifo_out[DATA_W +: MASK_W];
  wire [DATA_W-1:0] drain_data = fifo_out[DATA_W-1:0];
  wire [DATA_W-1:0] old_word = mem[drain_idx];
  wire [DATA_W-1:0] lane_keep;
  wire [DATA_W-1:0] merged = (drain_data & ~lane_keep) | (old_word & lane_keep);

  genvar g;
  generate
    for (g = 0; g < MASK_W; g++) begin : g_lane
      assign lane_keep[g*LANE_W +: LANE_W] = {LANE_W{drain_mask_n[g]}};
    end
  endgenerate

  sync_word_fifo #(
    .WIDTH(FW),
    .DEPTH(`WFIFO_DEPTH)
  ) u_wfifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(beat_take),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(!read_take),
    .out_data(fifo_out)
  );

  always_ff @(posedge ref_clk) begin
    if (drain) mem[drain_idx] <= merged;
  end

  // ----------------------------------------
  // Read burst and output drivers
  // ----------------------------------------
  logic [DATA_W-1:0] rbuf [4];
  logic [2:0] rd_left;
  logic [`BEAT_W-1:0] rd_beat;
  assign read_take = k_p_rise && !rd_sel_n_s;
  wire [2:0] next_rd_left = read_take ? `BURST_LEN
    : (launch_edge && rd_left != 3'h0) ? rd_left - 3'h1 : rd_left;

  generate
    for (g = 0; g < 4; g++) begin : g_rbuf
      always_ff @(posedge ref_clk) begin
        if (read_take) rbuf[g] <= mem[{addr_s[MEM_ADDR_W-1:0], 2'(g)}];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_left <= `RD_LEFT_RST;
      rd_beat <= '0;
      read_data <= DATA_W'(`RDATA_RST);
      read_data_oe <= `SYNC_RST;
      return_strobe <= `SYNC_RST;
    end else begin
      rd_left <= next_rd_left;
      return_strobe <= strobe_src;
      if (read_take) rd_beat <= '0;
      else if (launch_edge && rd_left != 3'h0) rd_beat <= rd_beat + 1'b1;
      // A take on the last beat's edge still sends that beat from the old buffer
      if (launch_edge && rd_left != 3'h0) begin
        read_data <= rbuf[rd_beat];
        read_data_oe <= 1'b1;
      end else if (launch_p_rise && rd_left == 3'h0) begin
        read_data_oe <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [IDX_W-1:0] last_idx;
  logic [LANE_W-1:0] last_lane0;
  always_ff @(posedge ref_clk) begin
    last_idx <= drain_idx;
    last_lane0 <= old_word[LANE_W-1:0];
  end

  // Transfers launched since the latest read take
  logic [2:0] sent_cnt;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sent_cnt <= 3'h0;
    end else if (read_take) begin
      sent_cnt <= 3'h0;
    end else if (launch_edge && rd_left != 3'h0) begin
      sent_cnt <= sent_cnt + 3'h1;
    end
  end

  a_write_start: assert property (@(posedge ref_clk) disable iff (rst)
    (wstate == W_IDLE && write_start) |=> wstate == W_B0)
    else $error("write select low did not open a burst");
  a_deselect_ignores: assert property (@(posedge ref_clk) disable iff (rst)
    (wstate == W_IDLE && k_p_rise && wr_sel_n_s) |=> wstate == W_IDLE && $stable(wr_addr))
    else $error("deselected write port changed state");
  a_idle_no_push: assert property (@(posedge ref_clk) disable iff (rst)
    beat_take |-> wstate != W_IDLE && (k_p_rise || k_n_rise))
    else $error("beat taken outside a burst");
  a_lane_masked: assert property (@(posedge ref_clk) disable iff (rst)
    (drain && drain_mask_n[0]) |=> mem[last_idx][LANE_W-1:0] == last_lane0)
    else $error("masked lane was written");
  a_burst_four: assert property (@(posedge ref_clk) disable iff (rst)
    read_take |=> rd_left == 3'h4 && rd_beat == 2'h0)
    else $error("read burst not loaded with four transfers");
  a_oe_release: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(read_data_oe) |-> $past(launch_p_rise) && $past(rd_left) == 3'h0)
    else $error("outputs released at wrong moment");
  a_launch_only: assert property (@(posedge ref_clk) disable iff (rst)
    !launch_edge |=> $stable(read_data))
    else $error("read data moved without a launch edge");
  a_strobe_tracks: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 return_strobe == $past(strobe_src))
    else $error("return strobe does not follow its clock");
  a_read_addr_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    (k_p_rise && rd_sel_n_s && rd_left == 3'h0) |=> rd_left == 3'h0)
    else $error("deselected read port started a burst");
  a_burst_sent_four: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(read_data_oe) |-> $past(sent_cnt) == 3'h4)
    else $error("read outputs released before four transfers");
  a_oe_needs_burst: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(read_data_oe) |-> $past(rd_left) != 3'h0)
    else $error("read outputs enabled without an active read");
  a_fifo_no_drop: assert property (@(posedge ref_clk) disable iff (rst)
    beat_take |-> fifo_in_ready)
    else $error("write beat lost to a full buffer");
endmodule : quad_rate_sram_port_logic

// file: bench/mem_ctrl_model.sv
// Memory controller model: free-running timing clocks, selects, address and data.
// Assumes the device samples every pin with its own ref_clk.
`timescale 1ns/1ps
module mem_ctrl_model #(
  parameter real HALF = 62.5,
  parameter real SKEW = 40.0
) (
  input wire logic ref_clk,
  input wire logic single_clock_mode,
  input wire logic [35:0] read_data,
  input wire logic read_data_oe,
  output logic in_clk_p,
  output logic in_clk_n,
  output logic out_clk_p,
  output logic out_clk_n,
  output logic write_port_select_n,
  output logic read_port_select_n,
  output logic [18:0] addr,
  output logic [35:0] write_data,
  output logic [3:0] byte_write_mask_n
);
  // ----------------------------------------
  // Clocks and pin drive
  // ----------------------------------------
  initial begin
    {in_clk_p, out_clk_p, addr, write_data} = '0;
    {write_port_select_n, read_port_select_n, byte_write_mask_n} = '1;
    #1.3;
    forever #HALF in_clk_p = ~in_clk_p;
  end
  assign in_clk_n = ~in_clk_p;
  // Output clock pair shifted to mimic board flight time
  always @(in_clk_p) out_clk_p <= #SKEW in_clk_p;
  assign out_clk_n = ~out_clk_p;

  // Changes land mid-way between link edges
  task automatic settle(input bit neg);
    if (neg) @(posedge in_clk_n);
    else @(posedge in_clk_p);
    repeat (8) @(negedge ref_clk);
  endtask : settle

  task automatic wr(input logic [18:0] a, input logic [143:0] d, input logic [15:0] m,
                    input bit sel);
    settle(1'b0);
    write_port_select_n = ~sel;
    addr = a;
    for (int i = 0; i < 4; i++) begin
      settle(i[0]);
      write_port_select_n = 1'b1;
      addr = ~a;
      write_data = d[36*i+:36];
      byte_write_mask_n = m[4*i+:4];
    end
    settle(1'b0);
    write_data = ~write_data;
    byte_write_mask_n = ~byte_write_mask_n;
  endtask : wr

  task automatic rd(input logic [18:0] a, input bit sel, output logic [143:0] q,
                    output logic [3:0] oe, output logic oe_end);
    settle(1'b0);
    read_port_select_n = ~sel;
    addr = a;
    settle(1'b0);
    read_port_select_n = 1'b1;
    addr = ~a;
    for (int i = 0; i < 4; i++) begin
      if (single_clock_mode) @(posedge in_clk_p or posedge in_clk_n);
      else @(posedge out_clk_p or posedge out_clk_n);
      repeat (8) @(negedge ref_clk);
      q[36*i+:36] = read_data;
      oe[i] = read_data_oe;
    end
    if (single_clock_mode) @(posedge in_clk_p);
    else @(posedge out_clk_p);
    repeat (8) @(negedge ref_clk);
    oe_end = read_data_oe;
  endtask : rd
endmodule : mem_ctrl_model

// file: bench/test_quad_rate_sram_port_logic.sv
// Self-checking bench for the quad-rate SRAM port logic.
// Assumes mem_ctrl_model drives every link pin of the device.
`timescale 1ns/1ps
module test_quad_rate_sram_port_logic;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic single_clock_mode = 1'b0;
  wire logic in_clk_p, in_clk_n, out_clk_p, out_clk_n, wr_sel_n, rd_sel_n;
  wire logic [18:0] addr;
  wire logic [35:0] write_data, read_data;
  wire logic [3:0] mask_n;
  wire logic read_data_oe, return_strobe;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [35:0] exp_mem [0:63];

  always #2 ref_clk = ~ref_clk;

  mem_ctrl_model ctl (.ref_clk(ref_clk), .single_clock_mode(single_clock_mode),
    .read_data(read_data), .read_data_oe(read_data_oe), .in_clk_p(in_clk_p),
    .in_clk_n(in_clk_n), .out_clk_p(out_clk_p), .out_clk_n(out_clk_n),
    .write_port_select_n(wr_sel_n), .read_port_select_n(rd_sel_n), .addr(addr),
    .write_data(write_data), .byte_write_mask_n(mask_n));

  quad_rate_sram_port_logic dut (.ref_clk(ref_clk), .rst(rst), .in_clk_p(in_clk_p),
    .in_clk_n(in_clk_n), .out_clk_p(out_clk_p), .out_clk_n(out_clk_n),
    .single_clock_mode(single_clock_mode), .write_port_select_n(wr_sel_n),
    .read_port_select_n(rd_sel_n), .addr(addr), .write_data(write_data),
    .byte_write_mask_n(mask_n), .read_data(read_data), .read_data_oe(read_data_oe),
    .return_strobe(return_strobe));

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic check(input logic [143:0] seen, input logic [143:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end

  task automatic do_wr(input logic [18:0] a, input logic [143:0] d, input logic [15:0] m,
                       input bit sel);
    ctl.wr(a, d, m, sel);
    for (int b = 0; b < 4; b++) begin
      for (int l = 0; l < 4; l++) begin
        if (sel && !m[4*b+l]) exp_mem[{a[3:0], b[1:0]}][9*l+:9] = d[36*b+9*l+:9];
      end
    end
  endtask : do_wr

  task automatic do_rd(input logic [18:0] a, input bit sel);
    logic [143:0] q;
    logic [143:0] want;
    logic [3:0] oe;
    logic oe_end;
    ctl.rd(a, sel, q, oe, oe_end);
    for (int b = 0; b < 4; b++) want[36*b+:36] = exp_mem[{a[3:0], b[1:0]}];
    if (sel) check(q, want);
    check(oe, sel ? 4'hf : 4'h0);
    check(oe_end, 1'b0);
  endtask : do_rd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_write_read;
    do_wr(19'h00001, 144'h0123456789abcdef0123456789abcdef0123, 16'h0000, 1'b1);
    do_wr(19'h00002, 144'hfedcba9876543210fedcba9876543210fedc, 16'h0000, 1'b1);
    do_rd(19'h00001, 1'b1);
    do_rd(19'h00002, 1'b1);
    $display("write_read done");
  endtask : t_write_read

  task automatic t_masks;
    do_wr(19'h00001, {4{36'h5a5a5a5a5}}, 16'hf421, 1'b1);
    do_rd(19'h00001, 1'b1);
    $display("masks done");
  endtask : t_masks

  task automatic t_deselect;
    do_wr(19'h00002, {4{36'h3c3c3c3c3}}, 16'h0000, 1'b0);
    do_rd(19'h00002, 1'b1);
    do_rd(19'h00003, 1'b0);
    $display("deselect done");
  endtask : t_deselect

  task automatic chk_strobe;
    @(posedge in_clk_p);
    repeat (8) @(negedge ref_clk);
    check(return_strobe, single_clock_mode);
    repeat (16) @(negedge ref_clk);
    check(return_strobe, !single_clock_mode);
  endtask : chk_strobe

  task automatic t_single;
    chk_strobe();
    @(negedge ref_clk);
    single_clock_mode = 1'b1;
    chk_strobe();
    do_rd(19'h00001, 1'b1);
    @(negedge ref_clk);
    single_clock_mode = 1'b0;
    $display("single clock done");
  endtask : t_single

  initial begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (10) @(negedge ref_clk);
    t_write_read();
    t_masks();
    t_deselect();
    t_single();
    end_sim();
  end
endmodule : test_quad_rate_sram_port_logic
